//--- verilog/iod_pin_mux.sv
// Purpose: direction control and function select for three shared io pins
// Assumes: straps are stable while reset is high and for a few clocks after
// Notes: pad output enables are active low; strap capture happens after release
//
// Overview of operation
// - pin 3 direction bit: 1 out, 0 in
// - pin 3 is dram line 9 unless straps
// - pin 2 direction bit: 1 out, 0 in
// - pin 2 is dram line 11 unless straps
// - pin 2 may be media power enable
// - pin 1 direction bit: 1 out, 0 in
// - pin 1 is dram line 10 unless straps
// - straps 0 and 00 make all three gpio
`default_nettype none
module iod_pin_mux (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // register port
  input wire logic I_REG_WR,
  input wire logic [8:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  // strap pins
  input wire logic [1:0] I_MEMORY_CONFIG_STRAPS,
  input wire logic I_MEDIA_PORT_STRAP,
  // alternate functions from the core
  input wire logic I_DRAM_ADDR_LINE_9,
  input wire logic I_DRAM_ADDR_LINE_10,
  input wire logic I_DRAM_ADDR_LINE_11,
  input wire logic I_MEDIA_PORT_POWER_ENABLE,
  // gpio output values and sampled inputs
  input wire logic [3:1] I_GPIO_OUT,
  output logic [3:1] O_GPIO_IN,
  // shared pads
  input wire logic I_GENERAL_IO_PIN_1,
  output logic O_GENERAL_IO_PIN_1,
  output logic O_GENERAL_IO_PIN_1_OE_N,
  input wire logic I_GENERAL_IO_PIN_2,
  output logic O_GENERAL_IO_PIN_2,
  output logic O_GENERAL_IO_PIN_2_OE_N,
  input wire logic I_GENERAL_IO_PIN_3,
  output logic O_GENERAL_IO_PIN_3,
  output logic O_GENERAL_IO_PIN_3_OE_N,
  // latched selection, for the rest of the chip
  output logic O_PIN2_IS_POWER_ENABLE
);
  iod_pkg::iod_state_type st, next_st;

  // pad drive from selection: gpio follows its direction bit, alternates drive always
  function automatic iod_pkg::iod_pad_type pad_drive(input logic is_gpio, input logic dir,
                                                     input logic gval, input logic alt);
    iod_pkg::iod_pad_type p;
    p.out = is_gpio ? gval : alt;
    p.oe_n = is_gpio ? ~dir : 1'b0;
    return p;
  endfunction

  // next state
  always_comb begin
    next_st = st;
    next_st.mem_sync1 = I_MEMORY_CONFIG_STRAPS;
    next_st.mem_sync2 = st.mem_sync1;
    next_st.media_sync1 = I_MEDIA_PORT_STRAP;
    next_st.media_sync2 = st.media_sync1;
    next_st.gpio_in_sync1 = {I_GENERAL_IO_PIN_3, I_GENERAL_IO_PIN_2, I_GENERAL_IO_PIN_1};
    next_st.gpio_in_sync2 = st.gpio_in_sync1;
    // wait until the straps have crossed both synchroniser stages, then capture once
    case (st.phase)
      iod_pkg::IOD_IN_RESET: begin
        next_st.phase = iod_pkg::IOD_SETTLE;
      end
      // second stage still holds its reset zero here, so capture waits one more clock
      iod_pkg::IOD_SETTLE: begin
        next_st.phase = iod_pkg::IOD_CAPTURE;
      end
      iod_pkg::IOD_CAPTURE: begin
        next_st.phase = iod_pkg::IOD_RUN;
        next_st.sel.pin3_gpio = (st.mem_sync2 == iod_pkg::IOD_MEM_STRAP_GPIO);
        next_st.sel.pin1_gpio = (st.mem_sync2 == iod_pkg::IOD_MEM_STRAP_GPIO);
        next_st.sel.pin2_gpio = (st.mem_sync2 == iod_pkg::IOD_MEM_STRAP_GPIO)
                                && (st.media_sync2 == iod_pkg::IOD_MEDIA_STRAP_GPIO);
        // media strap set and dram not using line 11: pin 2 carries power enable
        next_st.sel.pin2_power = (st.media_sync2 != iod_pkg::IOD_MEDIA_STRAP_GPIO)
                                 && (st.mem_sync2 != iod_pkg::IOD_MEM_STRAP_ALL_DRAM);
      end
      iod_pkg::IOD_RUN: begin
        next_st.phase = iod_pkg::IOD_RUN; // selection frozen until reset
      end
      default: begin
        next_st.phase = iod_pkg::IOD_RUN;
      end
    endcase
    // register write; reserved bits stay zero
    if (I_REG_WR && (I_REG_ADDR == iod_pkg::IOD_CFG_OFFSET)) begin
      next_st.cfg = I_REG_WDATA & iod_pkg::IOD_CFG_WMASK;
    end
    next_st.rdata = (I_REG_ADDR == iod_pkg::IOD_CFG_OFFSET) ? st.cfg : 8'h00;
    // pads; direction bit ignored whenever the alternate owns the pin
    next_st.pad3 = pad_drive(st.sel.pin3_gpio, st.cfg[iod_pkg::IOD_BIT_PIN3], I_GPIO_OUT[3],
                             I_DRAM_ADDR_LINE_9);
    next_st.pad1 = pad_drive(st.sel.pin1_gpio, st.cfg[iod_pkg::IOD_BIT_PIN1], I_GPIO_OUT[1],
                             I_DRAM_ADDR_LINE_10);
    next_st.pad2 = pad_drive(st.sel.pin2_gpio, st.cfg[iod_pkg::IOD_BIT_PIN2], I_GPIO_OUT[2],
                             st.sel.pin2_power ? I_MEDIA_PORT_POWER_ENABLE : I_DRAM_ADDR_LINE_11);
    // until the straps are captured every pad stays released
    if (st.phase != iod_pkg::IOD_RUN) begin
      next_st.pad1 = '{out: 1'b0, oe_n: 1'b1};
      next_st.pad2 = '{out: 1'b0, oe_n: 1'b1};
      next_st.pad3 = '{out: 1'b0, oe_n: 1'b1};
    end
  end

  // state register; constants only under reset
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      st <= '0;
      st.phase <= iod_pkg::IOD_IN_RESET;
      st.cfg <= iod_pkg::IOD_CFG_RESET;
      st.pad1 <= '{out: 1'b0, oe_n: 1'b1};
      st.pad2 <= '{out: 1'b0, oe_n: 1'b1};
      st.pad3 <= '{out: 1'b0, oe_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign O_REG_RDATA = st.rdata;
  assign O_GPIO_IN = st.gpio_in_sync2;
  assign O_GENERAL_IO_PIN_1 = st.pad1.out;
  assign O_GENERAL_IO_PIN_1_OE_N = st.pad1.oe_n;
  assign O_GENERAL_IO_PIN_2 = st.pad2.out;
  assign O_GENERAL_IO_PIN_2_OE_N = st.pad2.oe_n;
  assign O_GENERAL_IO_PIN_3 = st.pad3.out;
  assign O_GENERAL_IO_PIN_3_OE_N = st.pad3.oe_n;
  assign O_PIN2_IS_POWER_ENABLE = st.sel.pin2_power;

  // checks
  sequence run_s;
    st.phase == iod_pkg::IOD_RUN;
  endsequence

  sequence settle_s;
    st.phase == iod_pkg::IOD_SETTLE;
  endsequence

  sequence capture_s;
    st.phase == iod_pkg::IOD_CAPTURE;
  endsequence

  pin3_dir_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and st.sel.pin3_gpio |=> (O_GENERAL_IO_PIN_3_OE_N == ~$past(st.cfg[iod_pkg::IOD_BIT_PIN3])))
    else $error("pin 3 direction does not follow its bit");
  pin3_dram_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and !st.sel.pin3_gpio |=> !O_GENERAL_IO_PIN_3_OE_N && O_GENERAL_IO_PIN_3 == $past(I_DRAM_ADDR_LINE_9))
    else $error("pin 3 not driving dram line 9");
  pin2_dir_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and st.sel.pin2_gpio |=> (O_GENERAL_IO_PIN_2_OE_N == ~$past(st.cfg[iod_pkg::IOD_BIT_PIN2])))
    else $error("pin 2 direction does not follow its bit");
  pin2_dram_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and !st.sel.pin2_gpio and !st.sel.pin2_power |=> !O_GENERAL_IO_PIN_2_OE_N
    && O_GENERAL_IO_PIN_2 == $past(I_DRAM_ADDR_LINE_11))
    else $error("pin 2 not driving dram line 11");
  pin2_power_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and st.sel.pin2_power |=> !O_GENERAL_IO_PIN_2_OE_N
    && O_GENERAL_IO_PIN_2 == $past(I_MEDIA_PORT_POWER_ENABLE))
    else $error("pin 2 not driving power enable");
  pin1_dir_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and st.sel.pin1_gpio |=> (O_GENERAL_IO_PIN_1_OE_N == ~$past(st.cfg[iod_pkg::IOD_BIT_PIN1])))
    else $error("pin 1 direction does not follow its bit");
  pin1_dram_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and !st.sel.pin1_gpio |=> !O_GENERAL_IO_PIN_1_OE_N && O_GENERAL_IO_PIN_1 == $past(I_DRAM_ADDR_LINE_10))
    else $error("pin 1 not driving dram line 10");
  all_gpio_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    st.phase == iod_pkg::IOD_CAPTURE && st.mem_sync2 == iod_pkg::IOD_MEM_STRAP_GPIO
    && st.media_sync2 == iod_pkg::IOD_MEDIA_STRAP_GPIO |=> st.sel.pin1_gpio && st.sel.pin2_gpio && st.sel.pin3_gpio)
    else $error("straps 0 and 00 did not select all gpio");
  sel_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s |=> $stable(st.sel))
    else $error("pin selection changed after capture");

  // release walks through settle and capture before any pad is driven
  capture_walk_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    st.phase == iod_pkg::IOD_IN_RESET |=> settle_s ##1 capture_s ##1 run_s)
    else $error("strap capture did not reach run in three clocks");
  pads_released_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    st.phase != iod_pkg::IOD_RUN |=> O_GENERAL_IO_PIN_1_OE_N && O_GENERAL_IO_PIN_2_OE_N
    && O_GENERAL_IO_PIN_3_OE_N)
    else $error("a pad was driven before the straps were captured");

  // driven gpio pads carry the core's output value one clock later
  pin3_value_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and st.sel.pin3_gpio |=> O_GENERAL_IO_PIN_3 == $past(I_GPIO_OUT[3]))
    else $error("pin 3 does not carry its gpio value");
  pin2_value_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and st.sel.pin2_gpio |=> O_GENERAL_IO_PIN_2 == $past(I_GPIO_OUT[2]))
    else $error("pin 2 does not carry its gpio value");
  pin1_value_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s and st.sel.pin1_gpio |=> O_GENERAL_IO_PIN_1 == $past(I_GPIO_OUT[1]))
    else $error("pin 1 does not carry its gpio value");

  // pin 2 has one owner only: a clash would fight the power switch on the board
  pin2_owner_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s |-> !(st.sel.pin2_gpio && st.sel.pin2_power))
    else $error("pin 2 claimed by gpio and power enable at once");

  // register port: masked write lands next clock, reads show the stored bits
  cfg_write_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_REG_WR && I_REG_ADDR == iod_pkg::IOD_CFG_OFFSET |=> st.cfg == ($past(I_REG_WDATA) & iod_pkg::IOD_CFG_WMASK))
    else $error("config write did not land");
  reg_read_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_REG_ADDR == iod_pkg::IOD_CFG_OFFSET |=> O_REG_RDATA == $past(st.cfg))
    else $error("config read does not show the stored bits");
  cfg_reserved_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (st.cfg & ~iod_pkg::IOD_CFG_WMASK) == 8'h00)
    else $error("reserved config bits are set");
  unmapped_read_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_REG_ADDR != iod_pkg::IOD_CFG_OFFSET |=> O_REG_RDATA == 8'h00)
    else $error("unmapped index did not read zero");

  // input path: pad level reaches the core after both synchroniser stages
  gpio_in_sync_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run_s |-> ##2 O_GPIO_IN == $past({I_GENERAL_IO_PIN_3, I_GENERAL_IO_PIN_2, I_GENERAL_IO_PIN_1}, 2))
    else $error("sampled pad levels are late or wrong");
endmodule
`default_nettype wire

//--- pkg/iod_pkg.sv
// Purpose: shared constants and types for the io pin direction mux
// Assumes: byte-wide register port, one register at the printed offset
// Notes: strap encodings select which pad function each shared pin carries
`default_nettype none
package iod_pkg;
  localparam logic [8:0] IOD_CFG_OFFSET = 9'h004;
  localparam logic [7:0] IOD_CFG_RESET = 8'h00;
  localparam logic [7:0] IOD_CFG_WMASK = 8'h0E;
  localparam int IOD_BIT_PIN1 = 1;
  localparam int IOD_BIT_PIN2 = 2;
  localparam int IOD_BIT_PIN3 = 3;
  localparam logic [1:0] IOD_MEM_STRAP_GPIO = 2'h0;
  localparam logic IOD_MEDIA_STRAP_GPIO = 1'b0;
  localparam logic [1:0] IOD_MEM_STRAP_ALL_DRAM = 2'h3;

  typedef enum {IOD_IN_RESET, IOD_SETTLE, IOD_CAPTURE, IOD_RUN} iod_phase_type;

  // one pad: output value, output enable (low = driving)
  typedef struct packed {
    logic out;
    logic oe_n;
  } iod_pad_type;

  // latched pin-function selection
  typedef struct packed {
    logic pin3_gpio;
    logic pin1_gpio;
    logic pin2_gpio;
    logic pin2_power;
  } iod_sel_type;

  typedef struct packed {
    iod_phase_type phase;
    logic [1:0] mem_sync1;
    logic [1:0] mem_sync2;
    logic media_sync1;
    logic media_sync2;
    iod_sel_type sel;
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic [2:0] gpio_in_sync1;
    logic [2:0] gpio_in_sync2;
    iod_pad_type pad1;
    iod_pad_type pad2;
    iod_pad_type pad3;
  } iod_state_type;
endpackage
`default_nettype wire

//--- bench/iod_host.sv
// Purpose: host model that writes and points at the pin direction register
// Assumes: caller sits just after a rising edge
// Notes: released write data is inverted so no stale value lingers
`default_nettype none
module iod_host (
  // bus toward the device
  input wire logic i_clk,
  output logic o_wr,
  output logic [8:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    o_wr = 1'b0;
    o_addr = 9'h000;
    o_wdata = 8'h00;
  end
  // one-cycle strobe, held until the edge that takes it
  task automatic write(input logic [8:0] a, input logic [7:0] d);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #10;
    o_wr = 1'b0;
    o_wdata = ~d;
    // one idle edge, so a following write never reassigns the strobe in this time step
    @(posedge i_clk);
    #10;
  endtask
  // aim the read port at an index
  task automatic point(input logic [8:0] a);
    o_addr = a;
  endtask
endmodule
`default_nettype wire

//--- bench/io_pin_direction_mux_bench.sv
// Purpose: self-checking bench for the io pin direction mux
// Assumes: inputs change 10 ns after the rising edge
// Notes: pad levels are resolved here from the enables, outside drive when released
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t %h %h", $time, a, b); end end
module io_pin_direction_mux_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr, media = 1'b0, pwr = 1'b0, is_pwr;
  logic [8:0] addr;
  logic [7:0] wdata, rdata;
  logic [1:0] mem = 2'h0;
  logic [2:0] dl = 3'h0;
  logic [3:1] gout = 3'h5, ext = 3'h2, gin, po, poe_n, pin, sel;
  int mismatches = 0, checks = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  // wire level: device drives when enable is low, else the outside level
  assign pin = (poe_n & ext) | (~poe_n & po);
  iod_host host (.i_clk(clk), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  iod_pin_mux dut (.I_CORE_CLK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .I_MEMORY_CONFIG_STRAPS(mem), .I_MEDIA_PORT_STRAP(media), .I_DRAM_ADDR_LINE_9(dl[0]),
    .I_DRAM_ADDR_LINE_10(dl[1]), .I_DRAM_ADDR_LINE_11(dl[2]), .I_MEDIA_PORT_POWER_ENABLE(pwr), .I_GPIO_OUT(gout),
    .O_GPIO_IN(gin), .I_GENERAL_IO_PIN_1(pin[1]), .O_GENERAL_IO_PIN_1(po[1]), .O_GENERAL_IO_PIN_1_OE_N(poe_n[1]),
    .I_GENERAL_IO_PIN_2(pin[2]), .O_GENERAL_IO_PIN_2(po[2]), .O_GENERAL_IO_PIN_2_OE_N(poe_n[2]),
    .I_GENERAL_IO_PIN_3(pin[3]), .O_GENERAL_IO_PIN_3(po[3]), .O_GENERAL_IO_PIN_3_OE_N(poe_n[3]),
    .O_PIN2_IS_POWER_ENABLE(is_pwr));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  // straps must stay put across release, so they are set while reset is high
  task automatic do_reset(input logic [1:0] m, input logic md);
    mem = m;
    media = md;
    rst = 1'b1;
    step(4);
    rst = 1'b0;
    step(4);
  endtask
  // reset value, write mask, unmapped index
  task automatic t_reg;
    host.point(9'h004);
    step(1);
    `CHK(rdata, 8'h00)
    host.write(9'h004, 8'hFF);
    host.write(9'h005, 8'h00);
    `CHK(rdata, 8'h00)
    host.point(9'h004);
    step(1);
    `CHK(rdata, 8'h0E)
  endtask
  // each direction bit alone, with the outside pulling the released pins
  task automatic t_dir;
    for (int k = 1; k <= 3; k++) begin
      sel = 3'h1 << (k - 1);
      host.write(9'h004, {4'h0, sel, 1'b0});
      step(5);
      `CHK(poe_n, ~sel)
      `CHK(gin, (sel & gout) | (~sel & ext))
    end
  endtask
  // all dram: pins follow the address lines with every direction bit written 0
  task automatic t_dram;
    do_reset(2'h3, 1'b0);
    host.write(9'h004, 8'h00);
    dl = 3'h3;
    mem = 2'h0;
    step(4);
    `CHK(poe_n, 3'h0)
    `CHK(po, 3'h5)
    `CHK(is_pwr, 1'b0)
  endtask
  // media strap: pin 2 is the power enable, pins 3 and 1 stay general
  task automatic t_power;
    do_reset(2'h0, 1'b1);
    pwr = 1'b1;
    step(2);
    `CHK(poe_n, 3'h5)
    `CHK({is_pwr, po[2]}, 2'h3)
    host.write(9'h004, 8'h0A);
    step(2);
    `CHK(poe_n, 3'h0)
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    do_reset(2'h0, 1'b0);
    t_reg();
    t_dir();
    t_dram();
    t_power();
    print_verdict();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
